// ===== rtl/rcr_bank.sv
/*
 Control and status register bank for four switching and two linear
 regulators, with the level-select pin choosing level codes.
 Assumes a transport block in front drives the register port on
 sys_clk, and that power-good and level-select are asynchronous.
*/
// Behaviour
// - Buck 2-4 use primary code, select low
// - Buck 2-4 use secondary code, select high
// - Buck block: primary, secondary, control at 0,1,2; buck 1 has no secondary
// - Linear: code then control, 0x50/0x58
// - Control bit 7 enables the regulator
// - Buck bit 2 selects 180 degree phase
// - Linear bit 2 enables shutdown drain
// - Control bit 1 enables fault interrupts
// - Control bit 0 reads power-good status
`include "rcr_consts.svh"
`default_nettype none

module rcr_bank
    import rcr_pkg::*;
#(
    parameter int NUM_REG = 6,
    parameter int NUM_BUCK = 4
) (
    input wire logic sys_clk, // 250 MHz clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [7:0] regAddr, // Register byte address
    input wire logic regWrEn, // Write strobe, one cycle
    input wire logic [7:0] regWrData, // Write data
    input wire logic regRdEn, // Read strobe, one cycle
    output logic [7:0] regRdData, // Read data, registered
    output logic regRdValid, // Read data valid pulse
    input wire logic level_select_pin, // Async level select
    input wire logic [NUM_REG-1:0] powerGood, // Async power-good
    output logic [NUM_REG-1:0] regEnable, // Regulator on
    output logic [NUM_BUCK-1:0] phaseShift, // Buck 180 deg
    output logic [1:0] shutdown_drain_enable, // Linear drain
    output logic [NUM_REG-1:0] fault_irq_enable, // Fault gate
    output rcr_level_type [NUM_REG-1:0] output_level_code, // Target
    output logic levelSelSynced // Filtered select level
);

    localparam int NSYNC = NUM_REG + 1;

    // Address decode, used by both write and read paths
    function automatic rcr_hit_type decode(input logic [7:0] a);
        rcr_hit_type h;
        h.hit = 1'b1;
        h.idx = `RCR_IDX_B1;
        h.field = RCR_FLD_PRI;
        case (a)
            `RCR_ADDR_B1_PRI: begin
                h.idx = `RCR_IDX_B1;
            end
            `RCR_ADDR_B1_CTRL: begin
                h.idx = `RCR_IDX_B1;
                h.field = RCR_FLD_CTRL;
            end
            `RCR_ADDR_B2_PRI: begin
                h.idx = `RCR_IDX_B2;
            end
            `RCR_ADDR_B2_SEC: begin
                h.idx = `RCR_IDX_B2;
                h.field = RCR_FLD_SEC;
            end
            `RCR_ADDR_B2_CTRL: begin
                h.idx = `RCR_IDX_B2;
                h.field = RCR_FLD_CTRL;
            end
            `RCR_ADDR_B3_PRI: begin
                h.idx = `RCR_IDX_B3;
            end
            `RCR_ADDR_B3_SEC: begin
                h.idx = `RCR_IDX_B3;
                h.field = RCR_FLD_SEC;
            end
            `RCR_ADDR_B3_CTRL: begin
                h.idx = `RCR_IDX_B3;
                h.field = RCR_FLD_CTRL;
            end
            `RCR_ADDR_B4_PRI: begin
                h.idx = `RCR_IDX_B4;
            end
            `RCR_ADDR_B4_SEC: begin
                h.idx = `RCR_IDX_B4;
                h.field = RCR_FLD_SEC;
            end
            `RCR_ADDR_B4_CTRL: begin
                h.idx = `RCR_IDX_B4;
                h.field = RCR_FLD_CTRL;
            end
            `RCR_ADDR_L5_LVL: begin
                h.idx = `RCR_IDX_L5;
            end
            `RCR_ADDR_L5_CTRL: begin
                h.idx = `RCR_IDX_L5;
                h.field = RCR_FLD_CTRL;
            end
            `RCR_ADDR_L6_LVL: begin
                h.idx = `RCR_IDX_L6;
            end
            `RCR_ADDR_L6_CTRL: begin
                h.idx = `RCR_IDX_L6;
                h.field = RCR_FLD_CTRL;
            end
            default: begin
                h.hit = 1'b0;
            end
        endcase
        return h;
    endfunction

    // Synchroniser: bit 0 is level select, the rest power-good
    logic [NSYNC-1:0] syncIn;
    logic [NSYNC-1:0] sync1_q, sync2_q, sync3_q;
    logic [NSYNC-1:0] filt_q, filt_d;

    assign syncIn = {powerGood, level_select_pin};

    // accept a change once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : gFilt
            always_comb begin
                if (sync2_q[g] == sync3_q[g]) begin
                    filt_d[g] = sync2_q[g];
                end else begin
                    filt_d[g] = filt_q[g];
                end
            end
        end
    endgenerate

    // Three stage chain; first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            filt_q <= '0;
        end else begin
            sync1_q <= syncIn;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= filt_d;
        end
    end

    logic selLevel;
    logic [NUM_REG-1:0] pgLevel;
    assign selLevel = filt_q[0];
    assign pgLevel = filt_q[NSYNC-1:1];
    assign levelSelSynced = selLevel;

    // Register storage
    rcr_level_type [NUM_REG-1:0] pri_q, pri_d;
    rcr_level_type [NUM_BUCK-1:0] sec_q, sec_d;
    rcr_ctrl_type [NUM_REG-1:0] ctrl_q, ctrl_d;
    rcr_hit_type wrHit;

    assign wrHit = decode(regAddr);

    // Write path; only defined fields are stored
    always_comb begin
        pri_d = pri_q;
        sec_d = sec_q;
        ctrl_d = ctrl_q;
        if (regWrEn && wrHit.hit) begin
            case (wrHit.field)
                RCR_FLD_PRI: begin
                    pri_d[wrHit.idx] = regWrData[`RCR_LVL_MSB:0];
                end
                RCR_FLD_SEC: begin
                    sec_d[wrHit.idx[1:0]] =
                        regWrData[`RCR_LVL_MSB:0];
                end
                RCR_FLD_CTRL: begin
                    ctrl_d[wrHit.idx].enable = regWrData[`RCR_BIT_EN];
                    // phase or drain from bit 2
                    ctrl_d[wrHit.idx].mode = regWrData[`RCR_BIT_MODE];
                    ctrl_d[wrHit.idx].faultIrq =
                        regWrData[`RCR_BIT_IRQ];
                end
                default: begin
                    ctrl_d = ctrl_q;
                end
            endcase
        end
    end

    // Register storage flops; reset leaves every regulator off
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_REG; i++) begin
                pri_q[i] <= `RCR_LVL_RST;
                ctrl_q[i] <= '{`RCR_BIT_RST, `RCR_BIT_RST,
                               `RCR_BIT_RST};
            end
            for (int i = 0; i < NUM_BUCK; i++) begin
                sec_q[i] <= `RCR_LVL_RST;
            end
        end else begin
            pri_q <= pri_d;
            sec_q <= sec_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Control outputs straight from the flops
    generate
        for (g = 0; g < NUM_REG; g++) begin : gCtrl
            assign regEnable[g] = ctrl_q[g].enable;
            assign fault_irq_enable[g] = ctrl_q[g].faultIrq;
        end
        for (g = 0; g < NUM_BUCK; g++) begin : gPhase
            // bucks use bit 2 as phase
            assign phaseShift[g] = ctrl_q[g].mode;
        end
        for (g = 0; g < 2; g++) begin : gDrain
            // linears use bit 2 as drain
            assign shutdown_drain_enable[g] =
                ctrl_q[NUM_BUCK+g].mode;
        end
    endgenerate

    // Target level selection, registered for clean outputs
    rcr_level_type [NUM_REG-1:0] lvl_q, lvl_d;

    always_comb begin
        lvl_d = pri_q;
        for (int i = `RCR_IDX_B2; i < NUM_BUCK; i++) begin
            lvl_d[i] = selLevel ? sec_q[i] : pri_q[i];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= lvl_d;
        end
    end

    assign output_level_code = lvl_q;

    // Read path; unmapped addresses answer zero
    logic [7:0] rdData_q, rdData_d;
    logic rdValid_q, rdValid_d;

    always_comb begin
        rdData_d = rdData_q;
        rdValid_d = regRdEn;
        if (regRdEn) begin
            rdData_d = `RCR_BYTE_ZERO;
            if (wrHit.hit) begin
                case (wrHit.field)
                    RCR_FLD_PRI: begin
                        rdData_d[`RCR_LVL_MSB:0] = pri_q[wrHit.idx];
                    end
                    RCR_FLD_SEC: begin
                        rdData_d[`RCR_LVL_MSB:0] =
                            sec_q[wrHit.idx[1:0]];
                    end
                    RCR_FLD_CTRL: begin
                        rdData_d[`RCR_BIT_EN] =
                            ctrl_q[wrHit.idx].enable;
                        rdData_d[`RCR_BIT_MODE] =
                            ctrl_q[wrHit.idx].mode;
                        rdData_d[`RCR_BIT_IRQ] =
                            ctrl_q[wrHit.idx].faultIrq;
                        rdData_d[`RCR_BIT_PG] = pgLevel[wrHit.idx];
                    end
                    default: begin
                        rdData_d = `RCR_BYTE_ZERO;
                    end
                endcase
            end
        end
    end

    // Read data holds until the next read strobe
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q <= `RCR_BYTE_ZERO;
            rdValid_q <= 1'b0;
        end else begin
            rdData_q <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;

endmodule

`default_nettype wire

// ===== rtl/rcr_consts.svh
/*
 Register map and bit positions for the regulator control bank.
 Assumes inclusion by bare name from the bank.
*/
`ifndef RCR_CONSTS_SVH
`define RCR_CONSTS_SVH

// Byte addresses on the internal register port
`define RCR_ADDR_B1_PRI 8'h10
`define RCR_ADDR_B1_CTRL 8'h12
`define RCR_ADDR_B2_PRI 8'h20
`define RCR_ADDR_B2_SEC 8'h21
`define RCR_ADDR_B2_CTRL 8'h22
`define RCR_ADDR_B3_PRI 8'h30
`define RCR_ADDR_B3_SEC 8'h31
`define RCR_ADDR_B3_CTRL 8'h32
`define RCR_ADDR_B4_PRI 8'h40
`define RCR_ADDR_B4_SEC 8'h41
`define RCR_ADDR_B4_CTRL 8'h42
`define RCR_ADDR_L5_LVL 8'h50
`define RCR_ADDR_L5_CTRL 8'h51
`define RCR_ADDR_L6_LVL 8'h58
`define RCR_ADDR_L6_CTRL 8'h59

// Regulator indices
`define RCR_IDX_B1 3'h0
`define RCR_IDX_B2 3'h1
`define RCR_IDX_B3 3'h2
`define RCR_IDX_B4 3'h3
`define RCR_IDX_L5 3'h4
`define RCR_IDX_L6 3'h5

// Control byte bit positions
`define RCR_BIT_EN 7
`define RCR_BIT_MODE 2
`define RCR_BIT_IRQ 1
`define RCR_BIT_PG 0
`define RCR_LVL_MSB 5

// Reset values
`define RCR_LVL_RST 6'h00
`define RCR_BIT_RST 1'b0
`define RCR_BYTE_ZERO 8'h00

`endif

// ===== rtl/rcr_pkg.sv
/*
 Types shared by the regulator control bank and its bench.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package rcr_pkg;
    typedef logic [5:0] rcr_level_type;
    typedef enum logic [1:0] {
        RCR_FLD_PRI,
        RCR_FLD_SEC,
        RCR_FLD_CTRL
    } rcr_field_type;
    typedef struct packed {
        logic enable;
        logic mode;
        logic faultIrq;
    } rcr_ctrl_type;
    typedef struct packed {
        logic hit;
        logic [2:0] idx;
        rcr_field_type field;
    } rcr_hit_type;
endpackage

`default_nettype wire

// ===== sim/rcr_host_model.sv
/*
 Host-side model that drives the level-select pin and power-good lines.
 Assumes the bench sets the wanted levels.
*/
`default_nettype none

module rcr_host_model (
    input wire logic selReq, // Wanted select
    input wire logic [5:0] pgReq, // Wanted status
    output logic level_select_pin, // To bank
    output logic [5:0] powerGood // To bank
);
    timeunit 1ns;
    timeprecision 100ps;
    // Skewed off the clock, as real pins are
    assign #1.3 level_select_pin = selReq;
    assign #0.7 powerGood = pgReq;
endmodule

`default_nettype wire

// ===== sim/rcr_bank_props.sv
/*
 Checker for the regulator control bank.
 Assumes it is bound to every rcr_bank instance.
*/
`default_nettype none

module rcr_bank_props
    import rcr_pkg::*;
#(
    parameter int NUM_REG = 6,
    parameter int NUM_BUCK = 4
) (
    input wire logic sys_clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic [7:0] regAddr, // Address
    input wire logic regWrEn, // Write
    input wire logic [7:0] regWrData, // Data
    input wire logic regRdEn, // Read
    input wire logic [7:0] regRdData, // Read data
    input wire logic regRdValid, // Read valid
    input wire logic level_select_pin, // Select
    input wire logic [NUM_REG-1:0] regEnable, // Enables
    input wire logic [NUM_BUCK-1:0] phaseShift, // Phase
    input wire logic [1:0] shutdown_drain_enable, // Drain
    input wire logic [NUM_REG-1:0] fault_irq_enable, // Irq gate
    input wire rcr_level_type [NUM_REG-1:0] output_level_code, // Codes
    input wire logic levelSelSynced // Synced select
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Write strobe to one address
    sequence s_wr(logic [7:0] a);
        regWrEn && regAddr == a;
    endsequence
    // Pin held long enough to pass the filter
    sequence s_selHi;
        level_select_pin [*8];
    endsequence
    a_read_valid: assert property (regRdEn |=> regRdValid)
        else $error("read not answered");
    a_no_spurious: assert property (!regRdEn |=> !regRdValid)
        else $error("valid without read");
    a_enable_wr: assert property (s_wr(8'h22) |=>
        regEnable[1] == $past(regWrData[7])) else $error("enable bad");
    a_enable_hold: assert property (!regWrEn |=>
        $stable(regEnable)) else $error("enable moved");
    a_phase_wr: assert property (s_wr(8'h32) |=>
        phaseShift[2] == $past(regWrData[2])) else $error("phase bad");
    a_drain_wr: assert property (s_wr(8'h59) |=>
        shutdown_drain_enable[1] == $past(regWrData[2]))
        else $error("drain bad");
    a_irq_gate: assert property (s_wr(8'h51) |=>
        fault_irq_enable[4] == $past(regWrData[1])) else $error("irq bad");
    a_linear_code: assert property (s_wr(8'h50) |=> ##1
        output_level_code[4] == $past(regWrData[5:0], 2))
        else $error("linear code bad");
    a_code_reserved: assert property (regRdEn && regAddr == 8'h50
        |=> regRdData[7:6] == 2'b00) else $error("reserved set");
    a_sel_high: assert property (s_selHi |-> levelSelSynced)
        else $error("select not high");
    a_sel_low: assert property (!level_select_pin [*8]
        |-> !levelSelSynced) else $error("select not low");
endmodule

bind rcr_bank rcr_bank_props #(.NUM_REG(NUM_REG), .NUM_BUCK(NUM_BUCK))
    u_props (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .level_select_pin(level_select_pin), .regEnable(regEnable),
    .phaseShift(phaseShift), .shutdown_drain_enable(shutdown_drain_enable),
    .fault_irq_enable(fault_irq_enable),
    .output_level_code(output_level_code),
    .levelSelSynced(levelSelSynced));

`default_nettype wire

// ===== sim/regulator_control_regs_test.sv
/*
 Self-checking bench for the regulator control bank.
 Assumes the host model and the bound checker are compiled alongside.
*/
`default_nettype none

module regulator_control_regs_test
    import rcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] MAP [16] = '{8'h10, 8'h12, 8'h20, 8'h21,
        8'h22, 8'h30, 8'h31, 8'h32, 8'h40, 8'h41, 8'h42, 8'h50, 8'h51,
        8'h58, 8'h59, 8'h11};
    localparam logic [7:0] CTL [6] = '{8'h12, 8'h22, 8'h32, 8'h42,
        8'h51, 8'h59};
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic selReq = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData, rdVal;
    logic regRdValid, levelSelSynced, level_select_pin;
    logic [5:0] pgReq = 6'h00;
    logic [5:0] powerGood, regEnable, fault_irq_enable;
    logic [3:0] phaseShift;
    logic [1:0] shutdown_drain_enable;
    rcr_level_type [5:0] output_level_code;
    int n_mismatch = 0;
    int checks = 0;

    always #2 sys_clk = ~sys_clk;

    rcr_bank dut (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .level_select_pin(level_select_pin), .powerGood(powerGood),
        .regEnable(regEnable), .phaseShift(phaseShift),
        .shutdown_drain_enable(shutdown_drain_enable),
        .fault_irq_enable(fault_irq_enable),
        .output_level_code(output_level_code),
        .levelSelSynced(levelSelSynced));
    rcr_host_model host (.selReq(selReq), .pgReq(pgReq),
        .level_select_pin(level_select_pin), .powerGood(powerGood));

    task end_sim;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    // Strobe held across exactly one rising edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge sys_clk);
        regWrEn = 1'b0;
    endtask

    task rd(input logic [7:0] a);
        int i;
        @(negedge sys_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge sys_clk);
        regRdEn = 1'b0;
        for (i = 0; i < 4 && regRdValid !== 1'b1; i++) @(negedge sys_clk);
        if (i == 4) begin
            n_mismatch++;
            end_sim;
        end
        rdVal = regRdData;
    endtask

    // Enable, irq gate and phase or drain of one regulator
    function automatic logic [7:0] ctlOut(int i);
        logic m;
        m = i < 4 ? phaseShift[i[1:0]] : shutdown_drain_enable[i[0]];
        return {5'h00, regEnable[i], fault_irq_enable[i], m};
    endfunction

    task t_reset;
        foreach (MAP[k]) begin
            rd(MAP[k]);
            chk("reset read", 8'h00, rdVal);
        end
        $display("test reset done");
    endtask

    task t_ctrl;
        for (int i = 0; i < 6; i++) begin
            pgReq = 6'h01 << i;
            repeat (8) @(negedge sys_clk);
            wr(CTL[i], 8'hff);
            chk("ctrl out", 8'h07, ctlOut(i));
            rd(CTL[i]);
            chk("ctrl read", 8'h87, rdVal);
            rd(CTL[(i + 1) % 6]);
            chk("other read", 8'h00, rdVal);
            wr(CTL[i], 8'h00);
            chk("ctrl off", 8'h00, ctlOut(i));
            rd(CTL[i]);
            chk("pg only", 8'h01, rdVal);
        end
        $display("test ctrl done");
    endtask

    task t_level;
        wr(8'h20, 8'hff);
        wr(8'h21, 8'h15);
        wr(8'h10, 8'h0a);
        wr(8'h50, 8'h2a);
        wr(8'h40, 8'h11);
        wr(8'h41, 8'h2c);
        rd(8'h20);
        chk("code read", 8'h3f, rdVal);
        chk("b2 primary", 8'h3f, {2'b00, output_level_code[1]});
        chk("b4 primary", 8'h11, {2'b00, output_level_code[3]});
        selReq = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("b2 early", 8'h3f, {2'b00, output_level_code[1]});
        repeat (8) @(negedge sys_clk);
        chk("b2 second", 8'h15, {2'b00, output_level_code[1]});
        chk("b4 second", 8'h2c, {2'b00, output_level_code[3]});
        chk("b1 code", 8'h0a, {2'b00, output_level_code[0]});
        chk("l5 code", 8'h2a, {2'b00, output_level_code[4]});
        chk("synced", 8'h01, {7'h00, levelSelSynced});
        selReq = 1'b0;
        repeat (10) @(negedge sys_clk);
        chk("b2 back", 8'h3f, {2'b00, output_level_code[1]});
        chk("b4 back", 8'h11, {2'b00, output_level_code[3]});
        $display("test level done");
    endtask

    // Reset in mid-run clears all; unmapped writes land nowhere
    task t_mid_reset;
        wr(8'h22, 8'h86);
        wr(8'h10, 8'h3f);
        chk("pre reset", 8'h07, ctlOut(1));
        @(negedge sys_clk);
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("in reset", 8'h00, ctlOut(1));
        chk("code reset", 8'h00, {2'b00, output_level_code[0]});
        rst_b = 1'b1;
        rd(8'h22);
        chk("ctrl reset", 8'h00, rdVal);
        wr(8'h11, 8'hff);
        rd(8'h11);
        chk("unmapped", 8'h00, rdVal);
        rd(8'h10);
        chk("b1 cleared", 8'h00, rdVal);
        $display("test mid reset done");
    endtask

    initial begin
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        t_reset;
        t_ctrl;
        t_level;
        t_mid_reset;
        end_sim;
    end
endmodule

`default_nettype wire
